/* inc/qstx_regs.vh */
// Constants for the four-channel transmit input path.
`ifndef QSTX_REGS_VH
`define QSTX_REGS_VH

// ----------------------------------------------------------------------
// Three-level select encodings
// ----------------------------------------------------------------------
`define QSTX_TL_LOW 2'h0
`define QSTX_TL_MID 2'h1
`define QSTX_TL_HIGH 2'h2

// ----------------------------------------------------------------------
// Character geometry
// ----------------------------------------------------------------------
`define QSTX_NUM_CHAN 4
`define QSTX_DATA_W 8
`define QSTX_CHAR_W 10
`define QSTX_ENTRY_W 12
`define QSTX_ENTRY_SPECIAL_CHAR_SELECT 11
`define QSTX_ENTRY_OPB 10
`define QSTX_WS_LEN 5'h10
`define QSTX_WS_LAST 4'hF

// ----------------------------------------------------------------------
// Fixed characters, bit 0 is the first bit on the line
// ----------------------------------------------------------------------
`define QSTX_VIOL_POS 10'h079
`define QSTX_VIOL_NEG 10'h386
`define QSTX_K28_5 8'hBC

// ----------------------------------------------------------------------
// Timing and reset values
// ----------------------------------------------------------------------
`define QSTX_CHAR_DIV 2
`define QSTX_INIT_LOW_EDGES 2'h2
`define QSTX_BIST_SEED 9'h1FF

`endif

/* rtl/qstx_input_path.v */
// Four-channel transmit input path: capture, phase-align, parity and character selection.
`timescale 1ns/1ns
`default_nettype none
`include "qstx_regs.vh"

module qstx_input_path #(
  parameter CHAR_DIV = `QSTX_CHAR_DIV,
  parameter BUF_AW = 2
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  // Static configuration
  input wire [1:0] i_tx_path_mode_select_hi,
  input wire [1:0] i_tx_path_mode_select_lo,
  input wire [1:0] i_parity_check_control,
  input wire [1:0] i_input_clock_source_select,
  input wire i_ref_rate_select,
  input wire [3:0] i_bist_enable,
  // Buffer initialisation, active low, asynchronous
  input wire i_phase_buffer_init_n,
  // Host character interface
  input wire [31:0] i_char_data_bits,
  input wire [7:0] i_char_ctrl_bits,
  input wire [3:0] i_odd_parity_bit,
  input wire i_special_char_select,
  input wire [3:0] i_per_chan_input_clock,
  // To the serial shifters
  output reg [39:0] o_tx_char,
  output reg o_char_tick,
  output reg [3:0] o_chan_error_flag
);

  localparam DEPTH = 1 << BUF_AW;

  // ----------------------------------------------------------------------
  // 8b/10b encoder, returns {running disparity after, code}
  // ----------------------------------------------------------------------
  function [10:0] qstx_enc;
    input [7:0] d;
    input k;
    input rd;
    reg [5:0] s6;
    reg [3:0] s4;
    reg [2:0] n6;
    reg [2:0] n4;
    reg rd6;
    reg alt;
    begin
      case (d[4:0])
        5'h00: s6 = 6'b100111;
        5'h01: s6 = 6'b011101;
        5'h02: s6 = 6'b101101;
        5'h03: s6 = 6'b110001;
        5'h04: s6 = 6'b110101;
        5'h05: s6 = 6'b101001;
        5'h06: s6 = 6'b011001;
        5'h07: s6 = 6'b111000;
        5'h08: s6 = 6'b111001;
        5'h09: s6 = 6'b100101;
        5'h0A: s6 = 6'b010101;
        5'h0B: s6 = 6'b110100;
        5'h0C: s6 = 6'b001101;
        5'h0D: s6 = 6'b101100;
        5'h0E: s6 = 6'b011100;
        5'h0F: s6 = 6'b010111;
        5'h10: s6 = 6'b011011;
        5'h11: s6 = 6'b100011;
        5'h12: s6 = 6'b010011;
        5'h13: s6 = 6'b110010;
        5'h14: s6 = 6'b001011;
        5'h15: s6 = 6'b101010;
        5'h16: s6 = 6'b011010;
        5'h17: s6 = 6'b111010;
        5'h18: s6 = 6'b110011;
        5'h19: s6 = 6'b100110;
        5'h1A: s6 = 6'b010110;
        5'h1B: s6 = 6'b110110;
        5'h1C: s6 = 6'b001110;
        5'h1D: s6 = 6'b101110;
        5'h1E: s6 = 6'b011110;
        default: s6 = 6'b101011;
      endcase
      if (k) begin
        s6 = 6'b001111;
      end
      n6 = {2'h0, s6[0]} + {2'h0, s6[1]} + {2'h0, s6[2]} +
           {2'h0, s6[3]} + {2'h0, s6[4]} + {2'h0, s6[5]};
      rd6 = (n6 != 3'h3) ? ~rd : rd;
      if (rd && ((n6 != 3'h3) || (!k && d[4:0] == 5'h07))) begin
        s6 = ~s6;
      end
      case (d[7:5])
        3'h0: s4 = 4'b1011;
        3'h1: s4 = 4'b1001;
        3'h2: s4 = 4'b0101;
        3'h3: s4 = 4'b1100;
        3'h4: s4 = 4'b1101;
        3'h5: s4 = 4'b1010;
        3'h6: s4 = 4'b0110;
        default: s4 = 4'b1110;
      endcase
      alt = (d[7:5] == 3'h7) && (k ||
            (!rd6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
            (rd6 && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)));
      if (alt) begin
        s4 = 4'b0111;
      end
      n4 = {2'h0, s4[0]} + {2'h0, s4[1]} + {2'h0, s4[2]} + {2'h0, s4[3]};
      if ((rd6 && ((n4 != 3'h2) || d[7:5] == 3'h3)) ||
          (k && !rd6 && (n4 == 3'h2) && d[7:5] != 3'h3)) begin
        s4 = ~s4;
      end
      qstx_enc = {((n4 != 3'h2) ? ~rd6 : rd6), s4[0], s4[1], s4[2], s4[3],
                  s6[0], s6[1], s6[2], s6[3], s6[4], s6[5]};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  wire enc_on = (i_tx_path_mode_select_hi != `QSTX_TL_LOW);
  wire atomic = (i_tx_path_mode_select_hi == `QSTX_TL_MID);
  wire sc_used = enc_on && (i_tx_path_mode_select_lo != `QSTX_TL_HIGH);
  wire buf_en = (i_input_clock_source_select != `QSTX_TL_LOW) || i_ref_rate_select;
  wire par_on = (i_parity_check_control != `QSTX_TL_LOW);
  wire par_ctl = (i_parity_check_control == `QSTX_TL_HIGH) || !enc_on;

  // ----------------------------------------------------------------------
  // Internal character tick
  // ----------------------------------------------------------------------
  reg [7:0] div_r;
  wire tick = (div_r == 8'h00);

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= 8'h00;
      o_char_tick <= 1'b0;
    end else begin
      div_r <= tick ? CHAR_DIV[7:0] - 8'h01 : div_r - 8'h01;
      o_char_tick <= tick;
    end
  end

  // ----------------------------------------------------------------------
  // Buffer initialisation synchroniser
  // ----------------------------------------------------------------------
  reg init_s1_r;
  reg init_s2_r;
  reg [1:0] init_cnt_r;
  reg init_hold_r;

  // The first stage feeds only the second; all decisions look at the second.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      init_s1_r <= 1'b1;
      init_s2_r <= 1'b1;
      init_cnt_r <= 2'h0;
      init_hold_r <= 1'b0;
    end else begin
      init_s1_r <= i_phase_buffer_init_n;
      init_s2_r <= init_s1_r;
      if (init_s2_r) begin
        init_cnt_r <= 2'h0;
        init_hold_r <= 1'b0;
      end else if (init_cnt_r != `QSTX_INIT_LOW_EDGES) begin
        init_cnt_r <= init_cnt_r + 2'h1;
      end else begin
        init_hold_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Self-test sequence source, period 511
  // ----------------------------------------------------------------------
  reg [8:0] lfsr_r;

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lfsr_r <= `QSTX_BIST_SEED;
    end else if (tick) begin
      lfsr_r <= {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
    end
  end

  // ----------------------------------------------------------------------
  // Input clock edges
  // ----------------------------------------------------------------------
  reg [3:0] iclk_d_r;
  wire [3:0] iclk_rise = i_per_chan_input_clock & ~iclk_d_r;
  wire [3:0] chan_special_char_select;

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      iclk_d_r <= 4'h0;
    end else begin
      iclk_d_r <= i_per_chan_input_clock;
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel path
  // ----------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < `QSTX_NUM_CHAN; ch = ch + 1) begin : g_chan
      reg [`QSTX_ENTRY_W-1:0] mem [0:DEPTH-1];
      reg [`QSTX_ENTRY_W-1:0] in_r;
      reg [BUF_AW:0] wptr_r;
      reg [BUF_AW:0] rptr_r;
      reg phase_err_r;
      reg rd_r;
      reg ws_act_r;
      reg [3:0] ws_cnt_r;
      reg wr;
      reg [`QSTX_ENTRY_W-1:0] src;
      reg [BUF_AW:0] fill;
      reg want_ws;
      reg cur_ws;
      reg [3:0] ws_idx;
      reg recentre;
      reg par_err;
      reg [10:0] enc;
      reg [9:0] chr;
      reg rd_nxt;
      reg [1:0] ct;
      reg sc;
      wire [`QSTX_ENTRY_W-1:0] pin_word = {i_special_char_select, i_odd_parity_bit[ch],
                                           i_char_ctrl_bits[2*ch+1:2*ch],
                                           i_char_data_bits[8*ch+7:8*ch]};

      assign chan_special_char_select[ch] = src[`QSTX_ENTRY_SPECIAL_CHAR_SELECT];

      always @* begin
        case (i_input_clock_source_select)
          `QSTX_TL_LOW: wr = tick;
          `QSTX_TL_MID: wr = iclk_rise[ch];
          default: wr = iclk_rise[0];
        endcase
        fill = wptr_r - rptr_r;
        src = buf_en ? mem[rptr_r[BUF_AW-1:0]] : in_r;
        // Channel A carries the select for all channels, so every lane sees
        // the same value in the same character slot.
        sc = sc_used && chan_special_char_select[0];
        ct = src[9:8];
        if (i_tx_path_mode_select_lo == `QSTX_TL_MID) begin
          want_ws = enc_on && ct[0] && (ct[1] || sc);
        end else begin
          want_ws = enc_on && (ct == 2'h3);
        end
        cur_ws = (atomic && ws_act_r) || want_ws;
        ws_idx = (cur_ws && ws_act_r) ? ws_cnt_r : 4'h0;
        recentre = atomic && phase_err_r && buf_en && want_ws && !ws_act_r;
        // Odd parity: the checked bits and the parity bit must XOR to one.
        par_err = par_on && !(^{src[7:0], src[`QSTX_ENTRY_OPB], par_ctl ? src[9:8] : 2'h0});
        if (ws_act_r && atomic) begin
          par_err = 1'b0;
        end
        enc = qstx_enc(src[7:0], 1'b0, rd_r);
        rd_nxt = rd_r;
        chr = src[9:0];
        if (phase_err_r && buf_en && !recentre) begin
          // Bypass keeps no running disparity, so it always sends the positive form.
          chr = (rd_r && enc_on) ? `QSTX_VIOL_NEG : `QSTX_VIOL_POS;
        end else if (i_bist_enable[ch]) begin
          enc = qstx_enc(lfsr_r[7:0], 1'b0, rd_r);
          chr = enc[9:0];
          rd_nxt = enc[10];
        end else if (par_err) begin
          if (enc_on) begin
            chr = rd_r ? `QSTX_VIOL_NEG : `QSTX_VIOL_POS;
          end else begin
            chr = `QSTX_VIOL_POS;
          end
        end else if (cur_ws) begin
          // Second and third commas carry the reversed disparity.
          enc = qstx_enc(`QSTX_K28_5, 1'b1,
                         rd_r ^ (ws_idx == 4'h1 || ws_idx == 4'h2));
          chr = enc[9:0];
          rd_nxt = ~rd_r;
        end else if (enc_on) begin
          if (!ct[0]) begin
            chr = enc[9:0];
          end else if (ct[1] || (i_tx_path_mode_select_lo == `QSTX_TL_LOW && sc)) begin
            enc = qstx_enc({src[7:5], 5'h1C}, 1'b1, rd_r);
            chr = enc[9:0];
          end else begin
            enc = qstx_enc(`QSTX_K28_5, 1'b1, rd_r);
            chr = enc[9:0];
          end
          rd_nxt = enc[10];
        end
      end

      always @(posedge i_sys_clk) begin
        if (buf_en && wr) begin
          mem[wptr_r[BUF_AW-1:0]] <= pin_word;
        end
      end

      always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          in_r <= {`QSTX_ENTRY_W{1'b0}};
          wptr_r <= DEPTH[BUF_AW:0] >> 1;
          rptr_r <= {(BUF_AW+1){1'b0}};
          phase_err_r <= 1'b0;
          rd_r <= 1'b0;
          ws_act_r <= 1'b0;
          ws_cnt_r <= 4'h0;
          o_tx_char[10*ch+9:10*ch] <= `QSTX_VIOL_POS;
          o_chan_error_flag[ch] <= 1'b0;
        end else begin
          if (!buf_en && wr) begin
            in_r <= pin_word;
          end
          // The writer starts half a buffer ahead, giving equal margin for
          // drift in either direction before a slip is flagged.
          if (init_hold_r || (tick && recentre)) begin
            wptr_r <= DEPTH[BUF_AW:0] >> 1;
            rptr_r <= {(BUF_AW+1){1'b0}};
            phase_err_r <= 1'b0;
          end else if (buf_en) begin
            if (wr && !(tick && fill == {(BUF_AW+1){1'b0}} && !wr)) begin
              wptr_r <= wptr_r + {{BUF_AW{1'b0}}, 1'b1};
            end
            if (tick) begin
              rptr_r <= rptr_r + {{BUF_AW{1'b0}}, 1'b1};
            end
            if ((wr && !tick && fill == DEPTH[BUF_AW:0]) ||
                (tick && !wr && fill == {(BUF_AW+1){1'b0}})) begin
              phase_err_r <= 1'b1;
            end
          end
          if (tick) begin
            rd_r <= rd_nxt;
            ws_act_r <= cur_ws && (ws_idx != `QSTX_WS_LAST);
            ws_cnt_r <= cur_ws ? ws_idx + 4'h1 : 4'h0;
            o_tx_char[10*ch+9:10*ch] <= chr;
            o_chan_error_flag[ch] <= (phase_err_r && buf_en && !recentre) ||
                                     par_err;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* bench/qstx_input_path_monitor.sv */
// Port checker for the four-channel transmit input path.
`timescale 1ns/1ns
`default_nettype none
`include "qstx_regs.vh"
module qstx_input_path_monitor #(
  parameter CHAR_DIV = 2
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  // Configuration
  input wire [1:0] i_tx_path_mode_select_hi,
  input wire [1:0] i_parity_check_control,
  input wire [1:0] i_input_clock_source_select,
  input wire i_ref_rate_select,
  input wire i_phase_buffer_init_n,
  // Results
  input wire [39:0] o_tx_char,
  input wire o_char_tick,
  input wire [3:0] o_chan_error_flag
);
  wire [6:0] cfg = {i_tx_path_mode_select_hi, i_parity_check_control,
    i_input_clock_source_select, i_ref_rate_select};
  wire par_off = i_parity_check_control == `QSTX_TL_LOW;
  wire buf_on = i_input_clock_source_select != `QSTX_TL_LOW;
  logic [6:0] cfg_r;
  logic [3:0] age_r;
  logic [7:0] gap_r;
  logic [3:0] lo_r;
  logic seen_r;
  // Counters saturate so that long runs never wrap into a false match.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r <= 7'h00;
      age_r <= 4'h0;
      gap_r <= 8'h00;
      lo_r <= 4'h0;
      seen_r <= 1'b0;
    end else begin
      cfg_r <= cfg;
      age_r <= (cfg != cfg_r) ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
      gap_r <= o_char_tick ? 8'h01 : gap_r + {7'h00, gap_r != 8'hFF};
      lo_r <= i_phase_buffer_init_n ? 4'h0 : lo_r + {3'h0, lo_r != 4'hF};
      seen_r <= seen_r | o_char_tick;
    end
  end
  // Mode changes leave a stale character in flight, so checks wait until it settles.
  wire calm = age_r == 4'hF;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  tick_spacing_a: assert property (
    o_char_tick && seen_r |-> gap_r == CHAR_DIV) else $error("tick spacing wrong");
  tick_gap_a: assert property (
    seen_r |-> gap_r <= CHAR_DIV) else $error("tick missing");
  tick_pulse_a: assert property (
    o_char_tick |=> !o_char_tick) else $error("tick longer than one cycle");
  char_hold_a: assert property (
    !o_char_tick |-> $stable(o_tx_char)) else $error("char changed between ticks");
  no_error_a: assert property (
    calm && par_off && !buf_on && !i_ref_rate_select |-> o_chan_error_flag == 4'h0)
    else $error("error flag without any check");
  init_sync_a: assert property (
    calm && par_off && buf_on && i_tx_path_mode_select_hi != `QSTX_TL_MID
      && |($past(o_chan_error_flag) & ~o_chan_error_flag)
      |-> $past(i_phase_buffer_init_n, 2) == 1'b0 && $past(i_phase_buffer_init_n, 3) == 1'b0)
    else $error("buffer error cleared without synchronised init");
  init_clear_a: assert property (
    lo_r >= 4'h8 && par_off && buf_on |-> o_chan_error_flag == 4'h0)
    else $error("buffer error kept during init");
  for (genvar g = 0; g < 4; g++) begin : lane
    viol_lane_a: assert property (
      calm && i_tx_path_mode_select_hi == `QSTX_TL_LOW && o_char_tick
        && o_chan_error_flag[g] |-> o_tx_char[10*g+:10] == `QSTX_VIOL_POS)
      else $error("flagged lane not violation");
  end
endmodule

bind qstx_input_path qstx_input_path_monitor #(.CHAR_DIV(CHAR_DIV)) u_mon (
  .i_sys_clk(i_sys_clk),
  .i_rst(i_rst),
  .i_tx_path_mode_select_hi(i_tx_path_mode_select_hi),
  .i_parity_check_control(i_parity_check_control),
  .i_input_clock_source_select(i_input_clock_source_select),
  .i_ref_rate_select(i_ref_rate_select),
  .i_phase_buffer_init_n(i_phase_buffer_init_n),
  .o_tx_char(o_tx_char),
  .o_char_tick(o_char_tick),
  .o_chan_error_flag(o_chan_error_flag)
);
`default_nettype wire

/* bench/qstx_host_model.sv */
// Host-side source of the four per-channel input clocks.
`timescale 1ns/1ns
`default_nettype none
module qstx_host_model #(
  parameter int HALF_NS = 16,
  parameter int SKEW_NS = 5
) (
  // Run enables
  input wire logic [3:0] i_run,
  // Per-channel input clocks
  output wire logic [3:0] o_per_chan_input_clock
);
  for (genvar g = 0; g < 4; g++) begin : chan
    logic clk_r;
    // Each lane lags the one before by a fixed skew, the last just inside half a character.
    // A stopped clock stands low, as a halted host would leave it.
    initial begin
      clk_r = 1'b0;
      #(g * SKEW_NS);
      forever begin
        #(HALF_NS);
        clk_r = i_run[g] ? ~clk_r : 1'b0;
      end
    end
    assign o_per_chan_input_clock[g] = clk_r;
  end
endmodule
`default_nettype wire

/* bench/qstx_input_path_tb.sv */
// Self-checking testbench for the transmit input path.
`timescale 1ns/1ns
`default_nettype none
`include "qstx_regs.vh"
module qstx_input_path_tb;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [1:0] hi = `QSTX_TL_LOW;
  logic [1:0] lo = `QSTX_TL_LOW;
  logic [1:0] par = `QSTX_TL_LOW;
  logic [1:0] src = `QSTX_TL_LOW;
  logic init_n = 1'b1;
  logic [31:0] dat = 32'h0000_0000;
  logic [7:0] ctl = 8'h00;
  logic [3:0] opb = 4'h0;
  logic [3:0] run = 4'hF;
  logic rate = 1'b0;
  logic [3:0] bist = 4'h0;
  logic special_char_select = 1'b0;
  logic [39:0] raw = 40'h00_0000_0000;
  logic [39:0] old;
  logic ok;
  wire [3:0] in_clk;
  wire [39:0] o_tx_char;
  wire o_char_tick;
  wire [3:0] o_chan_error_flag;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] pd [2] = '{32'hFF00_A55A, 32'h00FF_5AA5};
  logic [7:0] pc [2] = '{8'hE4, 8'h1B};

  always #4 i_sys_clk = ~i_sys_clk;

  qstx_host_model #(.HALF_NS(16), .SKEW_NS(5)) host (
    .i_run(run),
    .o_per_chan_input_clock(in_clk)
  );
  // Four cycles a character give the sampled input clocks a safe margin.
  qstx_input_path #(.CHAR_DIV(4), .BUF_AW(2)) uut (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_tx_path_mode_select_hi(hi),
    .i_tx_path_mode_select_lo(lo),
    .i_parity_check_control(par),
    .i_input_clock_source_select(src),
    .i_ref_rate_select(rate),
    .i_bist_enable(bist),
    .i_phase_buffer_init_n(init_n),
    .i_char_data_bits(dat),
    .i_char_ctrl_bits(ctl),
    .i_odd_parity_bit(opb),
    .i_special_char_select(special_char_select),
    .i_per_chan_input_clock(in_clk),
    .o_tx_char(o_tx_char),
    .o_char_tick(o_char_tick),
    .o_chan_error_flag(o_chan_error_flag)
  );

  task automatic finish_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk40(input string name, input logic [39:0] exp, input logic [39:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk4(input string name, input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic ticks(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge i_sys_clk);
        #1;
        k++;
      end while (o_char_tick !== 1'b1 && k < 20);
      if (k >= 20) begin
        n_mismatch++;
        finish_test();
      end
    end
  endtask

  // Parity is made good over data, plus control when asked, then spoiled per mask.
  task automatic load(input logic [31:0] d, input logic [7:0] c, input logic [3:0] bad,
      input logic withc);
    for (int i = 0; i < 4; i++) begin
      opb[i] = ~(^d[8*i+:8] ^ (withc & ^c[2*i+:2])) ^ bad[i];
      raw[10*i+:10] = {c[2*i+:2], d[8*i+:8]};
    end
    dat = d;
    ctl = c;
  endtask

  function automatic logic [39:0] viol(input logic [39:0] r, input logic [3:0] m);
    for (int i = 0; i < 4; i++) begin
      if (m[i]) r[10*i+:10] = `QSTX_VIOL_POS;
    end
    return r;
  endfunction

  // A lane matches when it carries the given code in either disparity form.
  function automatic logic [3:0] kmask(input logic [9:0] k);
    for (int i = 0; i < 4; i++) begin
      kmask[i] = o_tx_char[10*i+:10] === k || o_tx_char[10*i+:10] === ~k;
    end
  endfunction

  task automatic pulse_init();
    init_n = 1'b0;
    repeat (10) @(posedge i_sys_clk);
    #1 init_n = 1'b1;
  endtask

  initial begin
    repeat (2) @(posedge i_sys_clk);
    chk40("reset char", {4{`QSTX_VIOL_POS}}, o_tx_char);
    chk4("reset flag", 4'h0, o_chan_error_flag);
    #1 i_rst = 1'b0;
    for (int p = 0; p < 2; p++) begin
      old = raw;
      load(pd[p], pc[p], 4'h0, 1'b0);
      ticks(1);
      if (p > 0) chk40("direct latency", old, o_tx_char);
      ticks(1);
      chk40("bypass char", raw, o_tx_char);
    end
    for (int m = 1; m < 3; m++) begin
      par = 2'(m);
      load(pd[0], pc[0], 4'hA, 1'b1);
      ticks(3);
      chk40("parity char", viol(raw, 4'hA), o_tx_char);
      chk4("parity flag", 4'hA, o_chan_error_flag);
      load(pd[0], pc[0], 4'h0, 1'b0);
      ticks(3);
      chk4("ctrl parity flag", 4'h6, o_chan_error_flag);
    end
    hi = `QSTX_TL_HIGH;
    lo = `QSTX_TL_HIGH;
    par = `QSTX_TL_MID;
    load(pd[0], 8'h02, 4'h0, 1'b0);
    ticks(3);
    chk4("enc mid flag", 4'h0, o_chan_error_flag);
    par = `QSTX_TL_HIGH;
    ticks(3);
    ok = o_tx_char[9:0] === `QSTX_VIOL_POS || o_tx_char[9:0] === `QSTX_VIOL_NEG;
    chk4("enc high flag", 4'h1, o_chan_error_flag);
    chk4("enc violation", 4'h1, {3'h0, ok});
    lo = `QSTX_TL_LOW;
    par = `QSTX_TL_LOW;
    special_char_select = 1'b1;
    load(32'h0000_0000, 8'h55, 4'h0, 1'b0);
    ticks(3);
    chk4("special char", 4'hF, kmask(10'h0BC));
    special_char_select = 1'b0;
    ticks(2);
    chk4("fill char", 4'hF, kmask(10'h17C));
    hi = `QSTX_TL_LOW;
    par = `QSTX_TL_LOW;
    src = `QSTX_TL_MID;
    pulse_init();
    load(pd[1], pc[1], 4'h0, 1'b0);
    ticks(6);
    chk40("buffer char", raw, o_tx_char);
    chk4("buffer flag", 4'h0, o_chan_error_flag);
    run = 4'h7;
    ticks(6);
    chk40("stall char", viol(raw, 4'h8), o_tx_char);
    chk4("stall flag", 4'h8, o_chan_error_flag);
    run = 4'hF;
    ticks(6);
    chk4("sticky flag", 4'h8, o_chan_error_flag);
    pulse_init();
    ticks(6);
    chk40("recentred char", raw, o_tx_char);
    chk4("recentred flag", 4'h0, o_chan_error_flag);
    src = `QSTX_TL_HIGH;
    run = 4'h1;
    pulse_init();
    ticks(6);
    chk40("shared clock char", raw, o_tx_char);
    chk4("shared clock flag", 4'h0, o_chan_error_flag);
    hi = `QSTX_TL_MID;
    lo = `QSTX_TL_HIGH;
    src = `QSTX_TL_MID;
    run = 4'h7;
    ticks(8);
    chk4("atomic stall flag", 4'h8, o_chan_error_flag);
    run = 4'hF;
    ctl = 8'hC0;
    ticks(8);
    chk4("word sync flag", 4'h0, o_chan_error_flag);
    chk4("word sync comma", 4'h8, kmask(10'h17C) & 4'h8);
    load(pd[1], pc[1], 4'h0, 1'b0);
    hi = `QSTX_TL_LOW;
    lo = `QSTX_TL_LOW;
    src = `QSTX_TL_LOW;
    rate = 1'b1;
    pulse_init();
    ticks(6);
    chk40("double rate char", raw, o_tx_char);
    chk4("double rate flag", 4'h0, o_chan_error_flag);
    bist = 4'h1;
    ticks(3);
    chk40("self test others", raw, {o_tx_char[39:10], raw[9:0]});
    chk4("self test lane", 4'h1, {3'h0, o_tx_char[9:0] !== raw[9:0]});
    finish_test();
  end
endmodule
`default_nettype wire
